// File: include/cisq_pkg.sv
// Purpose : Shared constants for the card identification link
// Assumes : One command line, frames sent MSB first
// Notes   : Times are in link clock periods
package cisq_pkg;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int CMD_LEN = 48;
  localparam int R1_LEN  = 48;
  localparam int R3_LEN  = 48;
  localparam int R2_LEN  = 136;
  localparam int CID_W   = 128;

  // ----------------------------------------
  // Command indices
  // ----------------------------------------
  localparam logic [5:0] IDX_GO_IDLE     = 6'h00;
  localparam logic [5:0] IDX_OP_COND     = 6'h01;
  localparam logic [5:0] IDX_ALL_CID     = 6'h02;
  localparam logic [5:0] IDX_SET_ADDR    = 6'h03;
  localparam logic [5:0] IDX_LOCK        = 6'h2a;
  localparam logic [5:0] IDX_APP_PREFIX  = 6'h37;
  localparam logic [5:0] IDX_GEN_BLOCK   = 6'h38;
  localparam logic [5:0] IDX_RESP_FILL   = 6'h3f;
  localparam int         GEN_DIR_BIT     = 0;

  // ----------------------------------------
  // Operating condition value
  // ----------------------------------------
  localparam logic [31:0] OCR_READY   = 32'h80ff8000;
  localparam logic [31:0] OCR_BUSY    = 32'h00ff8000;
  localparam int          OCR_BUSY_BIT = 31;
  localparam logic [23:0] OCR_WINDOW  = 24'hff8000;
  localparam int          STAT_ST_LSB = 9;

  // ----------------------------------------
  // Timing in link clock periods
  // ----------------------------------------
  localparam logic [7:0] NCR_MIN     = 8'h02;
  localparam logic [7:0] NCR_MAX     = 8'h40;
  localparam logic [7:0] NID_TIMEOUT = 8'h05;
  localparam logic [7:0] NRC_GAP     = 8'h08;

  typedef enum logic [2:0] {
    CST_IDLE  = 3'h0,
    CST_READY = 3'h1,
    CST_IDENT = 3'h2,
    CST_STBY  = 3'h3,
    CST_INACT = 3'h7
  } cisq_card_state_t;

  // CRC7, polynomial x^7 + x^3 + 1, over the first 40 bits
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
    begin
      fb   = d[i] ^ c[6];
      c    = {c[5:0], fb};
      c[3] = c[3] ^ fb;
    end
    return c;
  endfunction : crc7

  function automatic logic [47:0] cmd_frame(input logic [5:0]  idx,
                                            input logic [31:0] arg);
    return {2'b01, idx, arg, crc7({2'b01, idx, arg}), 1'b1};
  endfunction : cmd_frame

  // Reserved or unsupported indices
  function automatic logic is_illegal(input logic [5:0] idx);
    return (idx == 6'h05) || (idx == 6'h06) || (idx == 6'h08) ||
           (idx == 6'h0e) || (idx == 6'h13) || (idx == 6'h15) ||
           (idx == 6'h16) || (idx == 6'h1f) || (idx == 6'h27) ||
           (idx == 6'h28) || (idx == 6'h29) || (idx > IDX_LOCK);
  endfunction : is_illegal

endpackage : cisq_pkg

// File: include/cisq_if.sv
// Purpose : Command line and link clock between host and card
// Assumes : Line pulled high when nobody pulls it low
// Notes   : Push-pull high equals the pull-up level here
interface cisq_if;

  logic link_clk;
  logic host_cmd_o;
  logic host_cmd_oe;
  logic card_cmd_o;
  logic card_cmd_oe;
  logic cmd_line;

  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  assign cmd_line = ~((host_cmd_oe & ~host_cmd_o) |
                      (card_cmd_oe & ~card_cmd_o));

  modport host (
    output link_clk,
    output host_cmd_o,
    output host_cmd_oe,
    input  cmd_line
  );

  modport card (
    input  link_clk,
    input  cmd_line,
    output card_cmd_o,
    output card_cmd_oe
  );

endinterface : cisq_if

// File: core/cisq_card.sv
// Purpose : Card end of the identification phase
// Assumes : Runs on the link clock; line is sampled at its rise
// Notes   : Only the command line is used in this phase
module cisq_card #(
  parameter logic [127:0] CARD_CID    = 128'h0123456789abcdef0f1e2d3c4b5a6901,
  parameter logic [23:0]  CARD_WINDOW = cisq_pkg::OCR_WINDOW
) (
  cisq_if.card              link,
  input  wire logic         nrst,
  input  wire logic         power_ready,
  output cisq_pkg::cisq_card_state_t state_o,
  output logic [15:0]       rca_o,
  output logic              illegal_o
);

  cisq_pkg::cisq_card_state_t state_q;
  cisq_pkg::cisq_card_state_t state_d;
  logic         pwr_s1_q;
  logic         pwr_s2_q;
  logic         rx_act_q;
  logic [5:0]   rx_cnt_q;
  logic [46:0]  rx_sr_q;
  logic [135:0] tx_sr_q;
  logic [7:0]   tx_left_q;
  logic [7:0]   tx_len_q;
  logic         arb_q;
  logic         drv_q;
  logic         bit_q;
  logic         pp_q;
  logic [15:0]  rca_q;
  logic         ill_q;
  logic         cmd_o_q;
  logic         cmd_oe_q;
  logic         frame_done;
  logic [47:0]  frame;
  logic         frame_ok;
  logic [5:0]   idx;
  logic [31:0]  arg;
  logic         resp_go;
  logic [135:0] resp;
  logic [7:0]   resp_len;
  logic         resp_arb;
  logic         rca_ld;
  logic         ill_c;
  logic         tx_busy;
  logic         mismatch;
  logic         cid_won;

  assign state_o     = state_q;
  assign rca_o       = rca_q;
  assign illegal_o   = ill_q;
  assign link.card_cmd_o  = cmd_o_q;
  assign link.card_cmd_oe = cmd_oe_q;

  // ----------------------------------------
  // Power-up level crossing
  // ----------------------------------------
  always_ff @(posedge link.link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwr_s1_q <= 1'b0;
      pwr_s2_q <= 1'b0;
    end
    else
    begin
      pwr_s1_q <= power_ready;
      pwr_s2_q <= pwr_s1_q;
    end
  end

  // ----------------------------------------
  // Command receiver
  // ----------------------------------------
  assign tx_busy    = (tx_left_q != 8'h00) || drv_q;
  assign frame_done = rx_act_q && (rx_cnt_q == 6'd47);
  assign frame      = {rx_sr_q, link.cmd_line};
  assign idx        = frame[45:40];
  assign arg        = frame[39:8];
  assign frame_ok   = frame_done && !frame[47] && frame[46] && frame[0] &&
                      (cisq_pkg::crc7(frame[47:8]) == frame[7:1]);

  always_ff @(posedge link.link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= 6'h00;
      rx_sr_q  <= 47'h0;
    end
    else if (tx_busy)
      rx_act_q <= 1'b0;
    else if (!rx_act_q && !link.cmd_line)
    begin
      rx_act_q <= 1'b1;
      rx_cnt_q <= 6'h01;
      rx_sr_q  <= 47'h0;
    end
    else if (rx_act_q)
    begin
      rx_sr_q  <= {rx_sr_q[45:0], link.cmd_line};
      rx_cnt_q <= rx_cnt_q + 6'h01;
      if (frame_done)
        rx_act_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  always_comb
  begin
    state_d  = state_q;
    resp_go  = 1'b0;
    resp     = 136'h0;
    resp_len = 8'h00;
    resp_arb = 1'b0;
    rca_ld   = 1'b0;
    ill_c    = 1'b0;
    if (frame_ok)
    begin
      if (cisq_pkg::is_illegal(idx))
        ill_c = 1'b1;
      else
      begin
        case (idx)
          cisq_pkg::IDX_GO_IDLE:
            if (state_q != cisq_pkg::CST_INACT)
              state_d = cisq_pkg::CST_IDLE;
          cisq_pkg::IDX_OP_COND:
            if (state_q == cisq_pkg::CST_IDLE ||
                state_q == cisq_pkg::CST_READY)
            begin
              if (arg[23:0] != 24'h0 && (arg[23:0] & CARD_WINDOW) == 24'h0)
                state_d = cisq_pkg::CST_INACT;
              else
              begin
                resp_go  = 1'b1;
                resp_len = 8'(cisq_pkg::R3_LEN);
                resp[135:88] = {2'b00, cisq_pkg::IDX_RESP_FILL,
                                pwr_s2_q ? cisq_pkg::OCR_READY
                                         : cisq_pkg::OCR_BUSY,
                                8'hff};
                if (pwr_s2_q)
                  state_d = cisq_pkg::CST_READY;
              end
            end
          cisq_pkg::IDX_ALL_CID:
            if (state_q == cisq_pkg::CST_READY)
            begin
              resp_go  = 1'b1;
              resp_arb = 1'b1;
              resp_len = 8'(cisq_pkg::R2_LEN);
              resp     = {2'b00, cisq_pkg::IDX_RESP_FILL, CARD_CID};
            end
          cisq_pkg::IDX_SET_ADDR:
            // address taken, card leaves the cycle
            if (state_q == cisq_pkg::CST_IDENT)
            begin
              state_d  = cisq_pkg::CST_STBY;
              rca_ld   = 1'b1;
              resp_go  = 1'b1;
              resp_len = 8'(cisq_pkg::R1_LEN);
              resp[135:88] = {2'b00, idx,
                19'h0, 1'b0, state_q, 9'h0,
                cisq_pkg::crc7({2'b00, idx, 19'h0, 1'b0, state_q, 9'h0}),
                1'b1};
            end
          default:
            state_d = state_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Card state
  // ----------------------------------------
  always_ff @(posedge link.link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= cisq_pkg::CST_IDLE;
      rca_q   <= 16'h0000;
      ill_q   <= 1'b0;
      pp_q    <= 1'b0;
    end
    else
    begin
      if (cid_won)
        state_q <= cisq_pkg::CST_IDENT;
      else
        state_q <= state_d;
      if (rca_ld)
        rca_q <= arg[31:16];
      ill_q <= ill_c;
      pp_q  <= (state_d == cisq_pkg::CST_STBY);
    end
  end

  // ----------------------------------------
  // Response transmitter
  // ----------------------------------------
  // Line sampled at the edge after each bit was put out
  assign mismatch = arb_q && drv_q && (link.cmd_line != bit_q);
  assign cid_won  = arb_q && drv_q && (tx_left_q == 8'h00) && !mismatch;

  always_ff @(posedge link.link_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_sr_q   <= 136'h0;
      tx_left_q <= 8'h00;
      tx_len_q  <= 8'h00;
      arb_q     <= 1'b0;
      drv_q     <= 1'b0;
      bit_q     <= 1'b1;
      cmd_o_q   <= 1'b0;
      cmd_oe_q  <= 1'b0;
    end
    else if (resp_go)
    begin
      tx_sr_q   <= resp;
      tx_len_q  <= resp_len;
      tx_left_q <= resp_len + cisq_pkg::NCR_MIN;
      arb_q     <= resp_arb;
    end
    // lost a bit, release at once
    else if (mismatch)
    begin
      tx_left_q <= 8'h00;
      drv_q     <= 1'b0;
      arb_q     <= 1'b0;
      cmd_oe_q  <= 1'b0;
    end
    else if (tx_left_q != 8'h00)
    begin
      tx_left_q <= tx_left_q - 8'h01;
      if (tx_left_q <= tx_len_q)
      begin
        drv_q   <= 1'b1;
        bit_q   <= tx_sr_q[135];
        tx_sr_q <= {tx_sr_q[134:0], 1'b0};
        cmd_o_q  <= pp_q ? tx_sr_q[135] : 1'b0;
        cmd_oe_q <= pp_q | ~tx_sr_q[135];
      end
    end
    else
    begin
      drv_q    <= 1'b0;
      arb_q    <= 1'b0;
      cmd_oe_q <= 1'b0;
    end
  end

endmodule : cisq_card

// File: core/cisq_host.sv
// Purpose : Host end that runs the identification phase
// Assumes : Link clock is clk divided by 2*LINK_HALF
// Notes   : Line is synchronised before use
module cisq_host #(
  parameter int LINK_HALF = 313
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  cisq_if.host              link,
  input  wire logic         start,
  input  wire logic [23:0]  host_window,
  output logic              busy_o,
  output logic              done_o,
  output logic              error_o,
  output logic [7:0]        card_count_o,
  output logic [31:0]       ocr_o,
  output logic [127:0]      cid_o
);

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_GAP  = 3'h1,
    H_TX   = 3'h2,
    H_WAIT = 3'h3,
    H_RX   = 3'h4
  } cisq_hstate_t;

  typedef enum logic [1:0] {
    P_OCR = 2'h0,
    P_CID = 2'h1,
    P_RCA = 2'h2
  } cisq_phase_t;

  cisq_hstate_t st_q;
  cisq_phase_t  ph_q;
  logic [9:0]   div_q;
  logic         lclk_q;
  logic         rise;
  logic         fall;
  logic         ln_s1_q;
  logic         ln_s2_q;
  logic [47:0]  tx_sr_q;
  logic [7:0]   cnt_q;
  logic [135:0] rx_sr_q;
  logic [135:0] rx_all;
  logic [7:0]   exp_len;
  logic [7:0]   limit;
  logic         ho_oe_q;
  logic [7:0]   count_q;
  logic         busy_q;
  logic         done_q;
  logic         err_q;
  logic [31:0]  ocr_q;
  logic [127:0] cid_q;

  assign busy_o       = busy_q;
  assign done_o       = done_q;
  assign error_o      = err_q;
  assign card_count_o = count_q;
  assign ocr_o        = ocr_q;
  assign cid_o        = cid_q;
  assign link.link_clk    = lclk_q;
  assign link.host_cmd_o  = 1'b0;
  assign link.host_cmd_oe = ho_oe_q;

  // ----------------------------------------
  // Link clock divider
  // ----------------------------------------
  // slow identification rate from clk
  assign rise = (div_q == 10'(LINK_HALF - 1)) && !lclk_q;
  assign fall = (div_q == 10'(LINK_HALF - 1)) && lclk_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_q  <= 10'h000;
      lclk_q <= 1'b0;
    end
    else if (div_q == 10'(LINK_HALF - 1))
    begin
      div_q  <= 10'h000;
      lclk_q <= ~lclk_q;
    end
    else
      div_q <= div_q + 10'h001;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ln_s1_q <= 1'b1;
      ln_s2_q <= 1'b1;
    end
    else
    begin
      ln_s1_q <= link.cmd_line;
      ln_s2_q <= ln_s1_q;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  assign rx_all  = {rx_sr_q[134:0], ln_s2_q};
  assign exp_len = (ph_q == P_CID) ? 8'(cisq_pkg::R2_LEN)
                                   : 8'(cisq_pkg::R1_LEN);
  assign limit   = (ph_q == P_CID) ? cisq_pkg::NID_TIMEOUT
                                   : cisq_pkg::NCR_MAX;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q    <= H_IDLE;
      ph_q    <= P_OCR;
      tx_sr_q <= 48'h0;
      cnt_q   <= 8'h00;
      rx_sr_q <= 136'h0;
      ho_oe_q <= 1'b0;
      count_q <= 8'h00;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      err_q   <= 1'b0;
      ocr_q   <= 32'h0;
      cid_q   <= 128'h0;
    end
    else
    begin
      done_q <= 1'b0;
      case (st_q)
        H_IDLE:
          if (start)
          begin
            st_q    <= H_GAP;
            ph_q    <= P_OCR;
            cnt_q   <= 8'h00;
            count_q <= 8'h00;
            busy_q  <= 1'b1;
            err_q   <= 1'b0;
          end
        H_GAP:
          if (rise)
          begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == cisq_pkg::NRC_GAP)
            begin
              st_q  <= H_TX;
              cnt_q <= 8'(cisq_pkg::CMD_LEN);
              case (ph_q)
                P_OCR:
                  tx_sr_q <= cisq_pkg::cmd_frame(cisq_pkg::IDX_OP_COND,
                                                 {8'h00, host_window});
                P_RCA:
                  tx_sr_q <= cisq_pkg::cmd_frame(cisq_pkg::IDX_SET_ADDR,
                                                 {count_q + 8'h01, 24'h0});
                default:
                  tx_sr_q <= cisq_pkg::cmd_frame(cisq_pkg::IDX_ALL_CID,
                                                 32'h0);
              endcase
            end
          end
        H_TX:
          if (fall)
          begin
            // open-drain on the command line only
            if (cnt_q != 8'h00)
            begin
              ho_oe_q <= ~tx_sr_q[47];
              tx_sr_q <= {tx_sr_q[46:0], 1'b0};
              cnt_q   <= cnt_q - 8'h01;
            end
            else
            begin
              ho_oe_q <= 1'b0;
              st_q    <= H_WAIT;
            end
          end
        H_WAIT:
          if (rise)
          begin
            if (!ln_s2_q)
            begin
              st_q    <= H_RX;
              cnt_q   <= 8'h01;
              rx_sr_q <= 136'h0;
            end
            // no start bit, search is over
            else if (cnt_q == limit)
            begin
              st_q   <= H_IDLE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              err_q  <= (ph_q != P_CID);
            end
            else
              cnt_q <= cnt_q + 8'h01;
          end
        H_RX:
          if (rise)
          begin
            rx_sr_q <= rx_all;
            cnt_q   <= cnt_q + 8'h01;
            if (cnt_q == exp_len - 8'h01)
            begin
              st_q  <= H_GAP;
              cnt_q <= 8'h00;
              case (ph_q)
                P_OCR:
                begin
                  ocr_q <= rx_all[39:8];
                  if (rx_all[8 + cisq_pkg::OCR_BUSY_BIT])
                    ph_q <= P_CID;
                end
                P_CID:
                begin
                  cid_q <= rx_all[127:0];
                  ph_q  <= P_RCA;
                end
                default:
                begin
                  count_q <= count_q + 8'h01;
                  ph_q    <= P_CID;
                end
              endcase
            end
          end
        default:
          st_q <= H_IDLE;
      endcase
    end
  end

endmodule : cisq_host

// File: verif/cisq_props.sv
// Purpose : Command line protocol checks between host and card
// Assumes : All signals sampled at the link clock rise
// Notes   : Host frames tracked by a bit counter
module cisq_props (
  input wire logic link_clk,
  input wire logic nrst,
  input wire logic host_cmd_o,
  input wire logic host_cmd_oe,
  input wire logic card_cmd_o,
  input wire logic card_cmd_oe,
  input wire logic cmd_line
);
  logic [7:0] idle_q;
  logic [5:0] fcnt_q;
  logic       hlast_q;
  logic       hstart;
  logic       cstart;

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!nrst);

  // ----
  // Helpers
  // ----
  // First host low starts a command; first card drive after a host drive marks a reply start
  assign hstart = (fcnt_q == 6'h00) && host_cmd_oe;
  assign cstart = card_cmd_oe && hlast_q;

  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst) idle_q <= 8'h00;
    else if (!cmd_line) idle_q <= 8'h00;
    else if (idle_q != 8'hff) idle_q <= idle_q + 8'h01;
  end

  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst) fcnt_q <= 6'h00;
    else if (hstart) fcnt_q <= 6'h01;
    else if (fcnt_q == 6'h2f) fcnt_q <= 6'h00;
    else if (fcnt_q != 6'h00) fcnt_q <= fcnt_q + 6'h01;
  end

  always_ff @(posedge link_clk or negedge nrst)
  begin
    if (!nrst) hlast_q <= 1'b1;
    else if (host_cmd_oe) hlast_q <= 1'b1;
    else if (card_cmd_oe) hlast_q <= 1'b0;
  end

  // ----
  // Properties
  // ----
  sequence s_cmd_head;
    !cmd_line ##1 cmd_line;
  endsequence
  sequence s_resp_head;
    !cmd_line ##1 !cmd_line;
  endsequence

  property p_one_driver;
    !(host_cmd_oe && card_cmd_oe);
  endproperty
  property p_host_od;
    host_cmd_oe |-> !host_cmd_o;
  endproperty
  property p_cmd_head;
    hstart |-> s_cmd_head;
  endproperty
  property p_cmd_end;
    fcnt_q == 6'h2f |-> cmd_line;
  endproperty
  property p_card_quiet;
    fcnt_q != 6'h00 |-> !card_cmd_oe;
  endproperty
  property p_ncr;
    cstart |-> idle_q >= 8'h03 && idle_q <= 8'h40;
  endproperty
  property p_resp_head;
    cstart |-> s_resp_head;
  endproperty
  property p_nrc;
    hstart && !hlast_q |-> idle_q >= 8'h08;
  endproperty
  property p_release;
    $fell(card_cmd_oe) |-> cmd_line;
  endproperty

  a_one_driver: assert property (p_one_driver)
    else $error("host and card drive together");
  a_host_od: assert property (p_host_od)
    else $error("host drives line high");
  a_cmd_head: assert property (p_cmd_head)
    else $error("bad command start");
  a_cmd_end: assert property (p_cmd_end)
    else $error("bad command end bit");
  a_card_quiet: assert property (p_card_quiet)
    else $error("card drives during command");
  a_ncr: assert property (p_ncr)
    else $error("reply gap out of range");
  a_resp_head: assert property (p_resp_head)
    else $error("bad reply start");
  a_nrc: assert property (p_nrc)
    else $error("command too soon after reply");
  a_release: assert property (p_release)
    else $error("line low after card release");
endmodule : cisq_props

// File: verif/card_identification_sequencer_tb.sv
// Purpose : Bench for host and card identification ends
// Assumes : Second link driven by bench to send odd commands
// Notes   : Short link divider keeps the run brief
module card_identification_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] CID1 = 128'h3c5a96e10f2d4b87a1c3e5f719283a4d;
  localparam logic [127:0] CID2 = 128'h7e814c2b9d0653fa28e4b1706c39d5a3;
  logic         clk, nrst, start, pr1, pr2, l2, run2, h2_oe;
  logic         ill, hi, ill1, ill2, busy, done, err;
  logic [23:0]  hw;
  logic [7:0]   cnt;
  logic [31:0]  operating_condition_value, rnd;
  logic [127:0] card_identity_number;
  logic [135:0] rsp;
  logic [15:0]  rca1, rca2;
  logic [5:0]   tbl [15] = '{6'h37, 6'h38, 6'h38, 6'h05, 6'h06, 6'h08,
    6'h0e, 6'h13, 6'h15, 6'h16, 6'h1f, 6'h27, 6'h28, 6'h29, 6'h2b};
  int           miscompares, checks, nb;
  cisq_pkg::cisq_card_state_t st1, st2;

  cisq_if if1 ();
  cisq_if if2 ();
  assign if2.link_clk = l2;
  assign if2.host_cmd_o = 1'b0;
  assign if2.host_cmd_oe = h2_oe;

  cisq_host #(.LINK_HALF(4)) cisq_host_inst (.clk(clk), .nrst(nrst),
    .link(if1.host), .start(start), .host_window(hw), .busy_o(busy),
    .done_o(done), .error_o(err), .card_count_o(cnt), .ocr_o(operating_condition_value),
    .cid_o(card_identity_number));
  cisq_card #(.CARD_CID(CID1)) cisq_card_inst (.link(if1.card),
    .nrst(nrst), .power_ready(pr1), .state_o(st1), .rca_o(rca1),
    .illegal_o(ill1));
  cisq_card #(.CARD_CID(CID2)) cisq_card_inst_2 (.link(if2.card),
    .nrst(nrst), .power_ready(pr2), .state_o(st2), .rca_o(rca2),
    .illegal_o(ill2));
  cisq_props cisq_props_inst (.link_clk(if1.link_clk), .nrst(nrst),
    .host_cmd_o(if1.host_cmd_o), .host_cmd_oe(if1.host_cmd_oe),
    .card_cmd_o(if1.card_cmd_o), .card_cmd_oe(if1.card_cmd_oe),
    .cmd_line(if1.cmd_line));

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [47:0] exp_r3(input logic [31:0] v);
    return {2'b00, 6'h3f, v, 7'h7f, 1'b1};
  endfunction : exp_r3

  task end_of_test;
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task chk(input logic [135:0] g, input logic [135:0] e);
    checks++;
    if (g !== e)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      miscompares++;
    end
  endtask : chk

  task automatic host_run(input logic [23:0] w);
    @(posedge clk);
    start <= 1'b1;
    hw <= w;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    chk(busy, 1'b1);
    for (int k = 0; k < 30000 && done !== 1'b1; k++)
      @(posedge clk);
    chk({done, busy}, 2'b10);
  endtask : host_run

  // Clock runs only while a frame and its reply are under way
  task automatic xfer(input logic [5:0] idx, input logic [31:0] arg,
                      input logic clash);
    logic [47:0] f;
    f = cisq_pkg::cmd_frame(idx, arg);
    rsp = '1;
    nb = 0;
    ill = 1'b0;
    hi = 1'b0;
    run2 = 1'b1;
    for (int i = 47; i >= 0; i--)
    begin
      @(negedge l2);
      h2_oe <= ~f[i];
    end
    for (int k = 0; k < 220; k++)
    begin
      @(posedge l2);
      if (ill2 === 1'b1) ill = 1'b1;
      if (if2.card_cmd_oe === 1'b1 && if2.card_cmd_o === 1'b1) hi = 1'b1;
      if ((nb > 0 || if2.cmd_line === 1'b0) && nb < 136)
      begin
        rsp = {rsp[134:0], if2.cmd_line};
        nb++;
      end
      @(negedge l2);
      h2_oe <= clash && (nb == 2);
    end
    run2 = 1'b0;
  endtask : xfer

  // ----
  // Clocks and watchdog
  // ----
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    l2 = 1'b0;
    // Offset keeps link edges apart from clk edges
    #0.5;
    forever
    begin
      #3;
      l2 = run2 ? ~l2 : 1'b0;
    end
  end

  initial
  begin
    #300000;
    miscompares++;
    end_of_test;
  end

  // ----
  // Main sequence
  // ----
  initial
  begin
    nrst = 1'b0;
    start = 1'b0;
    pr1 = 1'b0;
    pr2 = 1'b0;
    run2 = 1'b0;
    h2_oe = 1'b0;
    hw = 24'h000000;
    rnd = 32'h000129fe;
    miscompares = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rnd = lfsr(rnd);
    fork
      host_run(rnd[23:0] | 24'h008000);
      begin
        repeat (400) @(posedge clk);
        pr1 <= 1'b1;
      end
    join
    chk(operating_condition_value, cisq_pkg::OCR_READY);
    chk(card_identity_number, CID1);
    chk({cnt, err}, 9'h002);
    chk({rca1, st1}, {16'h0100, cisq_pkg::CST_STBY});
    // Identified card stays deaf to a new round
    host_run(24'hff8000);
    chk({cnt, err, st1}, {8'h00, 1'b1, cisq_pkg::CST_STBY});
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    host_run(24'h000100);
    chk({err, st1}, {1'b1, cisq_pkg::CST_INACT});
    rnd = lfsr(rnd);
    xfer(cisq_pkg::IDX_APP_PREFIX, rnd, 1'b0);
    chk({ill, nb[7:0], st2}, {9'h100, cisq_pkg::CST_IDLE});
    xfer(cisq_pkg::IDX_OP_COND, 32'h0, 1'b0);
    chk(rsp[135:88], exp_r3(cisq_pkg::OCR_BUSY));
    @(posedge clk);
    pr2 <= 1'b1;
    xfer(cisq_pkg::IDX_OP_COND, 32'h0, 1'b0);
    chk(rsp[135:88], exp_r3(cisq_pkg::OCR_READY));
    chk({hi, st2}, {1'b0, cisq_pkg::CST_READY});
    for (int i = 0; i < 15; i++)
    begin
      rnd = lfsr(rnd);
      xfer(i == 14 ? 6'h2b + 6'(rnd % 21) : tbl[i], {rnd[31:1], i[0]},
           1'b0);
      chk({ill, nb[7:0], st2}, {9'h100, cisq_pkg::CST_READY});
    end
    xfer(cisq_pkg::IDX_ALL_CID, rnd, 1'b1);
    chk({rsp[132:0], st2}, {133'h0, cisq_pkg::CST_READY} | ~136'h7);
    xfer(cisq_pkg::IDX_ALL_CID, rnd, 1'b0);
    chk(rsp, {2'b00, 6'h3f, CID2});
    chk(st2, cisq_pkg::CST_IDENT);
    xfer(cisq_pkg::IDX_SET_ADDR, {16'h00a5, rnd[15:0]}, 1'b0);
    chk({rsp[135:128], rsp[107:105]}, {8'h03, 3'h2});
    chk({hi, rca2, st2}, {1'b1, 16'h00a5, cisq_pkg::CST_STBY});
    xfer(cisq_pkg::IDX_ALL_CID, rnd, 1'b0);
    chk({nb[7:0], st2}, {8'h00, cisq_pkg::CST_STBY});
    xfer(cisq_pkg::IDX_GO_IDLE, 32'h0, 1'b0);
    xfer(cisq_pkg::IDX_OP_COND, 32'h00000100, 1'b0);
    chk({nb[7:0], st2}, {8'h00, cisq_pkg::CST_INACT});
    xfer(cisq_pkg::IDX_GO_IDLE, 32'h0, 1'b0);
    chk(st2, cisq_pkg::CST_INACT);
    end_of_test;
  end
endmodule : card_identification_sequencer_tb
